/* oms_consts.svh */
`ifndef OMS_CONSTS_SVH
`define OMS_CONSTS_SVH
`define OMS_REG_PASSWORD 16'h0065
`define OMS_REG_CODE 16'h0066
`define OMS_CODE_OFF 16'h0001
`define OMS_CODE_MAN 16'h0002
`define OMS_CODE_AUTO 16'h0003
`define OMS_EVT_OFF 16'h03e9
`define OMS_EVT_MAN 16'h03ea
`define OMS_EVT_AUTO 16'h03eb
`define OMS_CLK_HZ 10000000
`define OMS_HOLD_MS 500
`define OMS_HOLD_CYC ((`OMS_CLK_HZ / 1000) * `OMS_HOLD_MS)
`define OMS_WINDOW_S 5
`define OMS_WINDOW_CYC (`OMS_CLK_HZ * `OMS_WINDOW_S)
`endif

/* oms_pkg.sv */
package oms_pkg;
   typedef enum logic [1:0]
   {
      OMS_OFF = 2'b00,
      OMS_MAN = 2'b01,
      OMS_AUTO = 2'b10
   } oms_mode_t;
   typedef enum logic [1:0]
   {
      OMS_APP_AUTOSTART = 2'b00,
      OMS_APP_DRIVE = 2'b01,
      OMS_APP_LIGHTING = 2'b10
   } oms_app_t;
   typedef struct packed
   {
      logic output_off_mode;
      logic output_manual_mode;
      logic output_automatic_mode;
      logic output_not_off_mode;
   } oms_outputs_t;
   typedef struct packed
   {
      logic status_off_mode;
      logic status_manual_mode;
      logic status_automatic_mode;
   } oms_status_t;
   typedef struct packed
   {
      logic valid;
      logic [15:0] code;
   } oms_event_t;
endpackage

/* oms_button_filter.sv */
`timescale 1ns/100ps
// Accepts a button only after it stays pressed for the hold time; one pulse per press.
module oms_button_filter
   import oms_pkg::*;
#(
   parameter int HOLD_CYC = 5000000
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pressed,
   output logic accepted
);
   logic [31:0] count;
   logic fired;
   wire logic at_hold = (count >= 32'(HOLD_CYC - 1));
   wire logic next_fire = pressed && at_hold && !fired;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count <= 32'h0;
         fired <= 1'b0;
         accepted <= 1'b0;
      end
      else
      begin
         count <= (pressed && !at_hold) ? count + 32'h1 : (pressed ? count : 32'h0);
         fired <= pressed && (fired || at_hold);
         accepted <= next_fire;
      end
   end
endmodule

/* oms_modbus_cmd.sv */
`timescale 1ns/100ps
`include "oms_consts.svh"
// Two-step password then code sequence on the holding registers.
module oms_modbus_cmd
   import oms_pkg::*;
#(
   parameter int WINDOW_CYC = 50000000
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire logic [15:0] wr_addr,
   input wire logic [15:0] wr_data,
   input wire logic [15:0] password,
   output logic cmd_valid,
   output oms_mode_t cmd_mode
);
   logic armed;
   logic [31:0] timer;
   wire logic pw_wr = wr_en && (wr_addr == `OMS_REG_PASSWORD);
   wire logic code_wr = wr_en && (wr_addr == `OMS_REG_CODE);
   wire logic pw_ok = pw_wr && (wr_data == password);
   wire logic expired = (timer >= 32'(WINDOW_CYC - 1));
   wire logic code_ok = (wr_data == `OMS_CODE_OFF) || (wr_data == `OMS_CODE_MAN)
      || (wr_data == `OMS_CODE_AUTO);
   wire logic fire = armed && code_wr && code_ok && !expired;
   wire oms_mode_t decoded = (wr_data == `OMS_CODE_OFF) ? OMS_OFF :
      ((wr_data == `OMS_CODE_MAN) ? OMS_MAN : OMS_AUTO);
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         armed <= 1'b0;
         timer <= 32'h0;
         cmd_valid <= 1'b0;
         cmd_mode <= OMS_OFF;
      end
      else
      begin
         // A bad password, an expiry or any code write ends the sequence.
         armed <= pw_wr ? pw_ok : (armed && !expired && !code_wr);
         timer <= pw_wr ? 32'h0 : (armed && !expired ? timer + 32'h1 : timer);
         cmd_valid <= fire;
         cmd_mode <= fire ? decoded : cmd_mode;
      end
   end
endmodule

/* oms_mode_selector.sv */
`timescale 1ns/100ps
`include "oms_consts.svh"
// Notes on behaviour
// - Off mode stops the engine, clears anomalies and allows programming.
// - Entering off disconnects load per application: breaker, clutch or lights.
// - Manual never self-starts; it stops on operator stop or a trip; protections stay on; programming blocked.
// - Manual gives operator load control; device may still force disconnect.
// - Automatic: device runs engine and load, ignores operator, blocks programming.
// - Buttons ignored while any remote input active; lock indicator shown.
// - Active remote input forces its mode; panel and port requests rejected.
// - With no remote input active, buttons and port commands work again.
// - Remote priority: off, then manual, then automatic.
// - After remote manual or automatic drops, mode stays; buttons may change it.
// - With only remote off configured, prior mode restores when it drops.
// - Port commands run only while no remote input is active.
// - Codes 1, 2, 3 select off, manual, automatic.
// - Each mode change logs event 1001, 1002 or 1003 when enabled.
// - Outputs for each mode plus one active in manual or automatic.
// - Status flags for off, manual and automatic.
module oms_mode_selector
   import oms_pkg::*;
#(
   parameter int HOLD_CYC = `OMS_HOLD_CYC,
   parameter int WINDOW_CYC = `OMS_WINDOW_CYC
)
(
   // Clock and reset.
   input wire logic SYS_CLK,
   input wire logic RESETN,
   // Configuration.
   input wire oms_app_t APPLICATION,
   input wire logic [2:0] REMOTE_CONFIGURED,
   input wire logic EVENT_ENABLE,
   input wire logic [15:0] COMMAND_PASSWORD,
   // Panel buttons and remote contacts, asynchronous.
   input wire logic BUTTON_STOP,
   input wire logic BUTTON_AUTO,
   input wire logic BUTTON_START,
   input wire logic REMOTE_OFF_INPUT,
   input wire logic REMOTE_MANUAL_INPUT,
   input wire logic REMOTE_AUTOMATIC_INPUT,
   // Holding register writes from the communication ports.
   input wire logic REG_WR,
   input wire logic [15:0] REG_ADDR,
   input wire logic [15:0] REG_WDATA,
   // Requests from the engine and load logic.
   input wire logic PROTECTION_TRIP,
   input wire logic AUTO_RUN_REQUEST,
   input wire logic OPERATOR_LOAD_CLOSE,
   input wire logic OPERATOR_ENGINE_START,
   input wire logic OPERATOR_ENGINE_STOP,
   // Mode results.
   output oms_mode_t MODE,
   output oms_outputs_t MODE_OUTPUTS,
   output oms_status_t MODE_STATUS,
   output logic LOCK_INDICATOR,
   output oms_event_t EVENT,
   // Engine and load actions.
   output logic ENGINE_RUN,
   output logic RESET_ANOMALIES,
   output logic PROGRAMMING_ALLOWED,
   output logic PROTECTIONS_ENABLED,
   output logic GENERATOR_BREAKER_CLOSE,
   output logic CLUTCH_ENGAGE,
   output logic LIGHTS_ON
);
   logic rst_meta;
   logic rst_n;
   always_ff @(posedge SYS_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // Every button and remote input passes two flip-flops before any logic reads it.
   logic [5:0] pin_meta;
   logic [5:0] pin_sync;
   wire logic [5:0] pin_raw = {BUTTON_STOP, BUTTON_AUTO, BUTTON_START,
      REMOTE_OFF_INPUT, REMOTE_MANUAL_INPUT, REMOTE_AUTOMATIC_INPUT};
   always_ff @(posedge SYS_CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_meta <= 6'h00;
         pin_sync <= 6'h00;
      end
      else
      begin
         pin_meta <= pin_raw;
         pin_sync <= pin_meta;
      end
   end

   logic [2:0] btn_hit;
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_btn
         oms_button_filter #(.HOLD_CYC(HOLD_CYC)) u_filter
         (
            .clk(SYS_CLK),
            .rst_n(rst_n),
            .pressed(pin_sync[gi + 3]),
            .accepted(btn_hit[gi])
         );
      end
   endgenerate

   logic cmd_valid;
   oms_mode_t cmd_mode;
   oms_modbus_cmd #(.WINDOW_CYC(WINDOW_CYC)) u_cmd
   (
      .clk(SYS_CLK),
      .rst_n(rst_n),
      .wr_en(REG_WR),
      .wr_addr(REG_ADDR),
      .wr_data(REG_WDATA),
      .password(COMMAND_PASSWORD),
      .cmd_valid(cmd_valid),
      .cmd_mode(cmd_mode)
   );

   // Only configured remote inputs count; an unconfigured pin is ignored.
   wire logic rem_off = pin_sync[2] && REMOTE_CONFIGURED[2];
   wire logic rem_man = pin_sync[1] && REMOTE_CONFIGURED[1];
   wire logic rem_auto = pin_sync[0] && REMOTE_CONFIGURED[0];
   wire logic remote_active = rem_off || rem_man || rem_auto;
   wire logic only_off_cfg = (REMOTE_CONFIGURED == 3'b100);
   wire oms_mode_t remote_mode = rem_off ? OMS_OFF : (rem_man ? OMS_MAN : OMS_AUTO);

   // Buttons map as stop to off, auto to automatic, start to manual.
   wire logic btn_req = !remote_active && (btn_hit != 3'b000);
   wire oms_mode_t btn_mode = btn_hit[2] ? OMS_OFF : (btn_hit[1] ? OMS_AUTO : OMS_MAN);
   wire logic cmd_req = !remote_active && cmd_valid;

   oms_mode_t mode;
   oms_mode_t saved_mode;
   logic rem_off_q;
   wire logic off_rise = rem_off && !rem_off_q;
   wire logic off_fall = !rem_off && rem_off_q;

   oms_mode_t next_mode;
   always_comb
   begin
      next_mode = mode;
      if (remote_active)
         next_mode = remote_mode;
      else if (off_fall && only_off_cfg)
         next_mode = saved_mode;
      else if (btn_req)
         next_mode = btn_mode;
      else if (cmd_req)
         next_mode = cmd_mode;
   end

   wire logic changed = (next_mode != mode);
   wire logic [15:0] evt_code = (next_mode == OMS_OFF) ? `OMS_EVT_OFF :
      ((next_mode == OMS_MAN) ? `OMS_EVT_MAN : `OMS_EVT_AUTO);

   always_ff @(posedge SYS_CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode <= OMS_OFF;
         saved_mode <= OMS_OFF;
         rem_off_q <= 1'b0;
         EVENT <= '0;
      end
      else
      begin
         mode <= next_mode;
         rem_off_q <= rem_off;
         saved_mode <= off_rise ? mode : saved_mode;
         EVENT <= '{valid: changed && EVENT_ENABLE, code: evt_code};
      end
   end

   // Engine and load. Manual leaves start and stop to the operator; a trip stops it.
   logic engine_run;
   logic load_close;
   wire logic next_run = (mode == OMS_OFF) ? 1'b0 :
      PROTECTION_TRIP ? 1'b0 :
      (mode == OMS_AUTO) ? AUTO_RUN_REQUEST :
      (OPERATOR_ENGINE_START || (engine_run && !OPERATOR_ENGINE_STOP));
   // Load opens a cycle before the engine stops on entering off, as it decodes next_mode; a trip clears both in the same cycle.
   wire logic next_load = (mode == OMS_OFF || next_mode == OMS_OFF) ? 1'b0 :
      PROTECTION_TRIP ? 1'b0 :
      (mode == OMS_AUTO) ? (AUTO_RUN_REQUEST && engine_run) :
      OPERATOR_LOAD_CLOSE;

   always_ff @(posedge SYS_CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         engine_run <= 1'b0;
         load_close <= 1'b0;
         MODE <= OMS_OFF;
         MODE_OUTPUTS <= '0;
         MODE_STATUS <= '0;
         LOCK_INDICATOR <= 1'b0;
         ENGINE_RUN <= 1'b0;
         RESET_ANOMALIES <= 1'b0;
         PROGRAMMING_ALLOWED <= 1'b0;
         PROTECTIONS_ENABLED <= 1'b0;
         GENERATOR_BREAKER_CLOSE <= 1'b0;
         CLUTCH_ENGAGE <= 1'b0;
         LIGHTS_ON <= 1'b0;
      end
      else
      begin
         engine_run <= next_run;
         load_close <= next_load;
         MODE <= next_mode;
         MODE_OUTPUTS <= '{output_off_mode: next_mode == OMS_OFF,
            output_manual_mode: next_mode == OMS_MAN,
            output_automatic_mode: next_mode == OMS_AUTO,
            output_not_off_mode: next_mode != OMS_OFF};
         MODE_STATUS <= '{status_off_mode: next_mode == OMS_OFF,
            status_manual_mode: next_mode == OMS_MAN,
            status_automatic_mode: next_mode == OMS_AUTO};
         LOCK_INDICATOR <= remote_active;
         ENGINE_RUN <= next_run;
         RESET_ANOMALIES <= (next_mode == OMS_OFF);
         PROGRAMMING_ALLOWED <= (next_mode == OMS_OFF);
         PROTECTIONS_ENABLED <= (next_mode != OMS_OFF);
         GENERATOR_BREAKER_CLOSE <= next_load && (APPLICATION == OMS_APP_AUTOSTART);
         CLUTCH_ENGAGE <= next_load && (APPLICATION == OMS_APP_DRIVE);
         LIGHTS_ON <= next_load && (APPLICATION == OMS_APP_LIGHTING);
      end
   end
endmodule

/* oms_mode_selector_assertions.sv */
`timescale 1ns/100ps
module oms_mode_selector_chk
   import oms_pkg::*;
(
   // Observed ports.
   input wire logic SYS_CLK,
   input wire logic RESETN,
   input wire oms_app_t APPLICATION,
   input wire logic [2:0] REMOTE_CONFIGURED,
   input wire logic EVENT_ENABLE,
   input wire logic REMOTE_OFF_INPUT,
   input wire logic PROTECTION_TRIP,
   input wire oms_mode_t MODE,
   input wire oms_outputs_t MODE_OUTPUTS,
   input wire oms_status_t MODE_STATUS,
   input wire logic LOCK_INDICATOR,
   input wire oms_event_t EVENT,
   input wire logic ENGINE_RUN,
   input wire logic RESET_ANOMALIES,
   input wire logic PROGRAMMING_ALLOWED,
   input wire logic PROTECTIONS_ENABLED,
   input wire logic GENERATOR_BREAKER_CLOSE,
   input wire logic CLUTCH_ENGAGE,
   input wire logic LIGHTS_ON
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RESETN);
   chk_status_outputs: assert property (MODE_STATUS == MODE_OUTPUTS[3:1])
      else $error("status and outputs disagree");
   chk_not_off_out: assert property (MODE_OUTPUTS.output_not_off_mode ==
      (MODE_OUTPUTS.output_manual_mode | MODE_OUTPUTS.output_automatic_mode))
      else $error("not-off output wrong");
   chk_status_mode: assert property ($stable(MODE) && MODE_STATUS != 3'h0
      |-> MODE_STATUS == (3'b100 >> MODE)) else $error("status does not match mode");
   chk_event_code: assert property (EVENT.valid |-> EVENT.code == 16'h03e9 + MODE)
      else $error("event code wrong");
   chk_event_change: assert property (EVENT_ENABLE && $changed(MODE) |-> EVENT.valid)
      else $error("mode change without event");
   chk_remote_off: assert property ((REMOTE_OFF_INPUT && REMOTE_CONFIGURED[2]) [*8]
      |-> MODE == OMS_OFF && LOCK_INDICATOR) else $error("remote off not forced");
   chk_off_actions: assert property (MODE == OMS_OFF && $past(MODE) == OMS_OFF
      && MODE_STATUS.status_off_mode |-> !ENGINE_RUN && RESET_ANOMALIES && PROGRAMMING_ALLOWED
      && !GENERATOR_BREAKER_CLOSE && !CLUTCH_ENGAGE && !LIGHTS_ON) else $error("off actions");
   chk_prog_blocked: assert property (MODE != OMS_OFF && $past(MODE) != OMS_OFF
      |-> !PROGRAMMING_ALLOWED && PROTECTIONS_ENABLED) else $error("programming not blocked");
   chk_app_only: assert property ($stable(APPLICATION) && APPLICATION == OMS_APP_AUTOSTART
      |-> !CLUTCH_ENGAGE && !LIGHTS_ON) else $error("wrong load output driven");
   chk_trip_open: assert property (PROTECTION_TRIP [*2]
      |-> !GENERATOR_BREAKER_CLOSE && !CLUTCH_ENGAGE && !LIGHTS_ON) else $error("trip kept load");
endmodule
bind oms_mode_selector oms_mode_selector_chk i_chk (.SYS_CLK, .RESETN, .APPLICATION,
   .REMOTE_CONFIGURED, .EVENT_ENABLE, .REMOTE_OFF_INPUT, .PROTECTION_TRIP, .MODE,
   .MODE_OUTPUTS, .MODE_STATUS, .LOCK_INDICATOR, .EVENT, .ENGINE_RUN, .RESET_ANOMALIES,
   .PROGRAMMING_ALLOWED, .PROTECTIONS_ENABLED, .GENERATOR_BREAKER_CLOSE, .CLUTCH_ENGAGE,
   .LIGHTS_ON);

/* oms_far_side.sv */
`timescale 1ns/100ps
`include "oms_consts.svh"
module oms_far_side
(
   // Clock.
   input wire logic clk,
   // Register writes and panel buttons.
   output logic wr,
   output logic [15:0] addr,
   output logic [15:0] data,
   output logic [2:0] btn
);
   initial
   begin
      wr = 1'b0;
      addr = 16'h0000;
      data = 16'h0000;
      btn = 3'h0;
   end
   // A released bus shows inverted values so a stale address is never read as a write.
   task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      data <= d;
      @(posedge clk);
      wr <= 1'b0;
      addr <= ~a;
      data <= ~d;
   endtask
   task automatic command(input logic [15:0] pw, input logic [15:0] code);
      wr_reg(`OMS_REG_PASSWORD, pw);
      wr_reg(`OMS_REG_CODE, code);
   endtask
   task automatic press(input int idx, input int n);
      @(posedge clk);
      btn[idx] <= 1'b1;
      repeat (n) @(posedge clk);
      btn[idx] <= 1'b0;
   endtask
endmodule

/* oms_mode_selector_tb.sv */
`timescale 1ns/100ps
`include "oms_consts.svh"
module oms_mode_selector_tb
   import oms_pkg::*;
;
   logic clk, rstn, evt_en, trip, ld, wr, lock, eng, ran, prog, prot, generator_breaker, clu, lit, es, ar;
   logic [2:0] rcfg, rem, btn;
   logic [15:0] pw, addr, wd;
   oms_app_t app;
   oms_mode_t mode;
   oms_outputs_t outs;
   oms_status_t stat;
   oms_event_t evt;
   int failures, samples_checked, em;
   int q[$];
   int codes[3] = '{2, 3, 1};
   oms_far_side fs (.clk(clk), .wr(wr), .addr(addr), .data(wd), .btn(btn));
   oms_mode_selector #(.HOLD_CYC(4), .WINDOW_CYC(20)) i_dut (.SYS_CLK(clk), .RESETN(rstn),
      .APPLICATION(app), .REMOTE_CONFIGURED(rcfg), .EVENT_ENABLE(evt_en),
      .COMMAND_PASSWORD(pw), .BUTTON_STOP(btn[0]), .BUTTON_AUTO(btn[1]),
      .BUTTON_START(btn[2]), .REMOTE_OFF_INPUT(rem[2]), .REMOTE_MANUAL_INPUT(rem[1]),
      .REMOTE_AUTOMATIC_INPUT(rem[0]), .REG_WR(wr), .REG_ADDR(addr), .REG_WDATA(wd),
      .PROTECTION_TRIP(trip), .AUTO_RUN_REQUEST(ar), .OPERATOR_LOAD_CLOSE(ld),
      .OPERATOR_ENGINE_START(es), .OPERATOR_ENGINE_STOP(1'b0), .MODE(mode),
      .MODE_OUTPUTS(outs), .MODE_STATUS(stat), .LOCK_INDICATOR(lock), .EVENT(evt),
      .ENGINE_RUN(eng), .RESET_ANOMALIES(ran), .PROGRAMMING_ALLOWED(prog),
      .PROTECTIONS_ENABLED(prot), .GENERATOR_BREAKER_CLOSE(generator_breaker), .CLUTCH_ENGAGE(clu),
      .LIGHTS_ON(lit));
   task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] s);
      samples_checked++;
      if (s !== e)
      begin
         failures++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Events are queued before the stimulus so the monitor always finds its expectation.
   task automatic set_mode(input int m);
      if (m != em)
         q.push_back(1001 + m);
      em = m;
   endtask
   task automatic chk_mode;
      cmp("mode", 16'(em), 16'(mode));
      cmp("status", 16'({em == 0, em == 1, em == 2}), 16'(stat));
      cmp("outputs", 16'({em == 0, em == 1, em == 2, em != 0}), 16'(outs));
   endtask
   task automatic test_done;
      $display("checked %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   always @(posedge clk)
      if (evt.valid === 1'b1)
         cmp("event", 16'(q.size() > 0 ? q.pop_front() : 0), evt.code);
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial
   begin
      idle(3000);
      failures++;
      test_done;
   end
   initial
   begin
      rstn = 1'b0;
      app = OMS_APP_AUTOSTART;
      rcfg = 3'b111;
      evt_en = 1'b1;
      rem = 3'h0;
      trip = 1'b0;
      ld = 1'b0;
      es = 1'b0;
      ar = 1'b0;
      em = 0;
      failures = 0;
      samples_checked = 0;
      pw = 16'($urandom(32'hb10f));
      idle(2);
      rstn <= 1'b1;
      idle(4);
      chk_mode;
      cmp("anomaly reset", 16'h1, 16'(ran));
      cmp("programming", 16'h1, 16'(prog));
      for (int i = 0; i < 3; i++)
      begin
         set_mode(codes[i] - 1);
         fs.command(pw, 16'(codes[i]));
         idle(3);
         chk_mode;
      end
      fs.command(pw ^ 16'h0001, `OMS_CODE_MAN);
      fs.command(pw, 16'h0004);
      fs.wr_reg(`OMS_REG_PASSWORD, pw);
      idle(22);
      fs.wr_reg(`OMS_REG_CODE, `OMS_CODE_AUTO);
      idle(3);
      chk_mode;
      fs.press(2, 2);
      idle(8);
      chk_mode;
      set_mode(1);
      fs.press(2, 8 + $urandom_range(4));
      idle(4);
      chk_mode;
      es <= 1'b1;
      idle(1);
      es <= 1'b0;
      idle(2);
      cmp("engine", 16'h1, 16'(eng));
      cmp("protections", 16'h1, 16'(prot));
      ld <= 1'b1;
      idle(3);
      cmp("breaker", 16'h1, 16'(generator_breaker));
      trip <= 1'b1;
      idle(3);
      cmp("breaker", 16'h0, 16'(generator_breaker));
      cmp("engine", 16'h0, 16'(eng));
      trip <= 1'b0;
      ld <= 1'b0;
      set_mode(2);
      fs.press(1, 10);
      idle(4);
      chk_mode;
      ar <= 1'b1;
      idle(3);
      cmp("engine", 16'h1, 16'(eng));
      cmp("breaker", 16'h1, 16'(generator_breaker));
      set_mode(1);
      rem <= 3'b011;
      idle(6);
      chk_mode;
      cmp("lock", 16'h1, 16'(lock));
      fs.press(0, 10);
      fs.command(pw, `OMS_CODE_AUTO);
      idle(4);
      chk_mode;
      rem <= 3'b000;
      idle(6);
      chk_mode;
      cmp("lock", 16'h0, 16'(lock));
      set_mode(0);
      fs.press(0, 10);
      idle(4);
      chk_mode;
      set_mode(2);
      fs.command(pw, `OMS_CODE_AUTO);
      idle(3);
      chk_mode;
      rcfg <= 3'b100;
      set_mode(0);
      rem <= 3'b100;
      idle(6);
      chk_mode;
      set_mode(2);
      rem <= 3'b000;
      idle(6);
      chk_mode;
      app <= OMS_APP_DRIVE;
      idle(3);
      cmp("clutch", 16'h1, 16'(clu));
      cmp("breaker", 16'h0, 16'(generator_breaker));
      app <= OMS_APP_LIGHTING;
      idle(3);
      cmp("lights", 16'h1, 16'(lit));
      cmp("clutch", 16'h0, 16'(clu));
      cmp("events left", 16'h0, 16'(q.size()));
      test_done;
   end
endmodule
